// [src/ddmr_pkg.sv]
// package: mode register programming constants and carriers
package ddmr_pkg;
   // apb register offsets
   localparam logic [7:0] DDMR_CTRL_OFS = 8'h00;
   localparam logic [7:0] DDMR_VALUE_OFS = 8'h04;
   localparam logic [7:0] DDMR_STATUS_OFS = 8'h08;
   // control register fields
   localparam int DDMR_CTRL_START = 0;
   localparam int DDMR_CTRL_ODT = 1;
   localparam int DDMR_CTRL_PD = 2;
   localparam int DDMR_CTRL_RST = 3;
   localparam int DDMR_CTRL_TGT = 4;
   // status register fields
   localparam int DDMR_ST_ERR = 4;
   // base register field positions
   localparam int DDMR_BL_LSB = 0;
   localparam int DDMR_BT_BIT = 3;
   localparam int DDMR_CL_LSB = 4;
   localparam int DDMR_DLLRST_BIT = 8;
   localparam int DDMR_WR_LSB = 9;
   localparam int DDMR_PPD_BIT = 12;
   localparam logic [16:0] DDMR_RSVD_MASK = 17'h1_2084;
   localparam logic [16:0] DDMR_VALUE_RST = 17'h0_0000;
   localparam logic [5:0] DDMR_CTRL_RST_VAL = 6'h00;
   // timing: cycles at the memory clock (same as pclk)
   localparam int DDMR_CK_PERIOD_NS = 10;
   localparam int DDMR_WR_TIME_NS = 15;
   localparam int DDMR_WR_CYC = (DDMR_WR_TIME_NS + DDMR_CK_PERIOD_NS - 1) / DDMR_CK_PERIOD_NS;
   localparam int DDMR_MRD_CYC = 4;
   localparam int DDMR_MOD_CYC = 12;
   localparam int DDMR_SPDEN_CYC = 12;
   localparam int DDMR_XPDLL_CYC = 10;
   localparam int DDMR_DLLK_CYC = 512;
   // command pins, one command cycle
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] bank;
      logic [15:0] addr;
   } ddmr_cmd_t;
   localparam ddmr_cmd_t DDMR_NOP = '{1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0000};
   typedef enum logic [1:0] {
      DDMR_IDLE = 2'b00,
      DDMR_ISSUE = 2'b01,
      DDMR_GAP = 2'b11
   } ddmr_state_t;
endpackage : ddmr_pkg

// [src/ddmr_ctrl.sv]
// module: host-side mode register set sequencer with apb control
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - set mode only when banks idle, no burst
// - wait mode-to-mode interval between set commands
// - only nop until mode-update interval ends; the sequencer still sends a further set once the mode-to-mode interval ends
// - every set carries full register value
// - keep cke high until power-down interval
// - latency change: wait locked exit interval
// - odt low from set through update interval
// - burst length field, 01 means per-command choice
// - wait dll lock period before reads
// - write recovery only 5,6,7,8,10,12
// - write recovery is time over period, rounded up
// - reserved bits 16,13,7,2 written zero
// - read latency 5 to 10 whole cycles
module ddmr_ctrl
   import ddmr_pkg::*;
#(
   parameter int MRD_CYC = DDMR_MRD_CYC,
   parameter int MOD_CYC = DDMR_MOD_CYC,
   parameter int SPDEN_CYC = DDMR_SPDEN_CYC,
   parameter int XPDLL_CYC = DDMR_XPDLL_CYC,
   parameter int DLLK_CYC = DDMR_DLLK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic array_idle,
   output ddmr_cmd_t dram_cmd,
   output logic dram_cke,
   output logic dram_odt,
   output logic dram_reset_n,
   output logic cmd_allowed,
   output logic read_allowed
);
   localparam int CW = 10;

   ddmr_state_t state;
   logic [5:0] ctrl;
   logic [16:0] value;
   logic pend;
   logic err;
   logic [CW-1:0] mrd_cnt;
   logic [CW-1:0] mod_cnt;
   logic [CW-1:0] spd_cnt;
   logic [CW-1:0] xp_cnt;
   logic [CW-1:0] dllk_cnt;
   logic [16:0] next_word;
   logic bad_word;
   logic cl_change;
   logic [2:0] sent_cl;
   logic acc;
   logic wr_acc;

   // smallest permitted recovery code covering the needed cycles
   function automatic logic [2:0] wr_code(input int cyc);
      if (cyc <= 5) return 3'h1;
      else if (cyc <= 6) return 3'h2;
      else if (cyc <= 7) return 3'h3;
      else if (cyc <= 8) return 3'h4;
      else if (cyc <= 10) return 3'h5;
      else return 3'h6;
   endfunction : wr_code

   // read latency codes 1..6 mean 5..10 cycles, half cycles unused
   function automatic logic cl_legal(input logic [2:0] code);
      return (code != 3'h0) && (code != 3'h7);
   endfunction : cl_legal

   // count down to zero, reload on demand
   function automatic logic [CW-1:0] tick(input logic [CW-1:0] c, input logic load,
                                          input int len);
      if (load) return CW'(len);
      else if (c != '0) return c - 1'b1;
      else return c;
   endfunction : tick

   assign acc = psel & penable & ~pready;
   assign wr_acc = acc & pwrite;

   // word placed on the address lines; base register gets fixed fields
   always_comb begin
      next_word = value;
      bad_word = 1'b0;
      if (ctrl[DDMR_CTRL_TGT+:2] == 2'b00) begin
         next_word = value & ~DDMR_RSVD_MASK;
         next_word[DDMR_WR_LSB+:3] = wr_code(DDMR_WR_CYC);
         bad_word = ~cl_legal(value[DDMR_CL_LSB+:3]) | (value[DDMR_BL_LSB+:2] == 2'b11);
      end else begin
         next_word[16] = 1'b0;
      end
   end

   // a latency change needs the locked exit interval afterwards;
   // the shadow already holds the new word, so compare with what the device has
   assign cl_change = (dram_cmd.bank[1:0] == 2'b00) &&
                      (dram_cmd.addr[DDMR_CL_LSB+:3] != sent_cl);

   // latency the device holds now; a device reset forgets it,
   // so the first base register set after one always counts as a change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sent_cl <= 3'h0;
      end else if (!dram_reset_n) begin
         sent_cl <= 3'h0;
      end else if (state == DDMR_ISSUE && dram_cmd.bank[1:0] == 2'b00) begin
         sent_cl <= dram_cmd.addr[DDMR_CL_LSB+:3];
      end
   end

   // apb slave: one wait state, then a registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc;
         pslverr <= acc && (paddr != DDMR_CTRL_OFS) && (paddr != DDMR_VALUE_OFS) &&
                    (paddr != DDMR_STATUS_OFS);
         prdata <= 32'h0000_0000;
         if (acc && !pwrite) begin
            unique case (paddr)
               DDMR_CTRL_OFS: prdata <= {26'h000_0000, ctrl[5:1], pend};
               DDMR_VALUE_OFS: prdata <= {15'h0000, value};
               DDMR_STATUS_OFS: prdata <= {25'h000_0000, dram_odt, dram_cke, err,
                                           spd_cnt == '0, read_allowed, cmd_allowed,
                                           state != DDMR_IDLE};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software control bits; start is a request, not a stored bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= DDMR_CTRL_RST_VAL;
      end else if (wr_acc && paddr == DDMR_CTRL_OFS) begin
         ctrl <= {pwdata[5:1], 1'b0};
      end
   end

   // shadow of the value; dll reset bit drops once sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= DDMR_VALUE_RST;
      end else if (ctrl[DDMR_CTRL_RST]) begin
         value <= DDMR_VALUE_RST;
      end else if (wr_acc && paddr == DDMR_VALUE_OFS) begin
         value <= pwdata[16:0];
      end else if (state == DDMR_ISSUE && dram_cmd.bank[1:0] == 2'b00) begin
         value[DDMR_DLLRST_BIT] <= 1'b0;
      end
   end

   // pending request and sticky error; setting beats clearing for err, a start while pend is high is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
         err <= 1'b0;
      end else begin
         if (wr_acc && paddr == DDMR_CTRL_OFS && pwdata[DDMR_CTRL_START] && !pend) begin
            pend <= 1'b1;
         end else if (state == DDMR_IDLE && pend && bad_word) begin
            pend <= 1'b0; // illegal codes are never sent
         end else if (state == DDMR_ISSUE) begin
            pend <= 1'b0;
         end
         if (state == DDMR_IDLE && pend && bad_word) begin
            err <= 1'b1;
         end else if (wr_acc && paddr == DDMR_STATUS_OFS && pwdata[DDMR_ST_ERR]) begin
            err <= 1'b0;
         end
      end
   end

   // sequencer: idle, one command cycle, mode-to-mode gap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= DDMR_IDLE;
      end else begin
         unique case (state)
            DDMR_IDLE: begin
               // power-down or device reset blocks new commands
               if (pend && !bad_word && array_idle && mrd_cnt == '0 && dram_cke &&
                   dram_reset_n) begin
                  state <= DDMR_ISSUE;
               end
            end
            DDMR_ISSUE: state <= DDMR_GAP;
            DDMR_GAP: begin
               if (mrd_cnt <= CW'(1)) state <= DDMR_IDLE;
            end
            default: state <= DDMR_IDLE;
         endcase
      end
   end

   // command pins: the set command for one cycle, nop otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dram_cmd <= DDMR_NOP;
      end else if (state == DDMR_IDLE && pend && !bad_word && array_idle &&
                   mrd_cnt == '0 && dram_cke && dram_reset_n) begin
         dram_cmd.cs_n <= 1'b0;
         dram_cmd.ras_n <= 1'b0;
         dram_cmd.cas_n <= 1'b0;
         dram_cmd.we_n <= 1'b0;
         dram_cmd.bank <= {1'b0, ctrl[DDMR_CTRL_TGT+:2]};
         dram_cmd.addr <= next_word[15:0];
      end else begin
         dram_cmd <= DDMR_NOP;
      end
   end

   // interval counters, loaded in the command cycle; xp_cnt only on a latency change, dllk_cnt only on a dll reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mrd_cnt <= '0;
         mod_cnt <= '0;
         spd_cnt <= '0;
         xp_cnt <= '0;
         dllk_cnt <= '0;
      end else begin
         mrd_cnt <= tick(mrd_cnt, state == DDMR_ISSUE, MRD_CYC - 1);
         mod_cnt <= tick(mod_cnt, state == DDMR_ISSUE, MOD_CYC - 1);
         spd_cnt <= tick(spd_cnt, state == DDMR_ISSUE, SPDEN_CYC - 1);
         xp_cnt <= tick(xp_cnt, state == DDMR_ISSUE && cl_change, XPDLL_CYC - 1);
         dllk_cnt <= tick(dllk_cnt, state == DDMR_ISSUE && dram_cmd.bank[1:0] == 2'b00 &&
                          dram_cmd.addr[DDMR_DLLRST_BIT], DLLK_CYC - 1);
      end
   end

   // command gates: other commands after update, reads after lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_allowed <= 1'b0;
         read_allowed <= 1'b0;
      end else begin
         cmd_allowed <= state == DDMR_IDLE && !pend && mod_cnt == '0 &&
                        xp_cnt == '0 && dram_cke;
         read_allowed <= state == DDMR_IDLE && !pend && mod_cnt == '0 &&
                         xp_cnt == '0 && dllk_cnt == '0 && dram_cke;
      end
   end

   // clock enable, termination and device reset pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dram_cke <= 1'b1;
         dram_odt <= 1'b0;
         dram_reset_n <= 1'b0;
      end else begin
         dram_reset_n <= ~ctrl[DDMR_CTRL_RST];
         // dll lock needs cke high, so power-down also waits for it
         dram_cke <= ~(ctrl[DDMR_CTRL_PD] && spd_cnt == '0 && dllk_cnt == '0 &&
                       state == DDMR_IDLE && !pend &&
                       !(state == DDMR_IDLE && pend));
         // termination forced low across the command and update interval
         dram_odt <= ctrl[DDMR_CTRL_ODT] && state == DDMR_IDLE && mod_cnt == '0 &&
                     !(pend && !bad_word && array_idle && mrd_cnt == '0);
      end
   end
endmodule : ddmr_ctrl

// [verification/ddmr_dev_model.sv]
// model: memory device side that latches mode register set commands
`timescale 1ns/1ns
module ddmr_dev_model
   import ddmr_pkg::*;
(
   input wire logic pclk,
   input wire ddmr_cmd_t dram_cmd,
   input wire logic dram_cke,
   input wire logic dram_reset_n
);
   logic [16:0] mode_reg [4];
   logic chop_fixed;
   logic interleaved;
   logic dll_on_in_pd;
   // burst and dll field decode of the base word, kept for waveform reading
   assign chop_fixed = mode_reg[0][1:0] == 2'b10;
   assign interleaved = mode_reg[0][3];
   assign dll_on_in_pd = mode_reg[0][12];
   // column of beat b inside the aligned block; writes ignore the low start bits
   function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] b,
                                          input logic inter, input logic chop,
                                          input logic wr);
      if (wr) return chop ? {start[2], b[1:0]} : b;
      else if (inter) return start ^ b;
      else return {start[2] ^ b[2], start[1:0] + b[1:0]};
   endfunction : beat_col
   // chop reads keep the eight-slot window and float its second half
   function automatic logic beat_float(input logic chop, input logic [2:0] b);
      return chop && b[2];
   endfunction : beat_float
   // settings stay until rewritten, but the dll reset bit drops a cycle after it is set; reset low wipes them all
   always @(posedge pclk or negedge dram_reset_n) begin
      if (!dram_reset_n) begin
         for (int i = 0; i < 4; i++) begin
            mode_reg[i] <= 17'h0_0000;
         end
      end else begin
         if (mode_reg[0][8]) begin
            mode_reg[0][8] <= 1'b0;
         end
         // later assignment wins, so a fresh dll reset survives one cycle
         if (dram_cke && ~|{dram_cmd.cs_n, dram_cmd.ras_n, dram_cmd.cas_n, dram_cmd.we_n}) begin
            mode_reg[dram_cmd.bank[1:0]] <= {1'b0, dram_cmd.addr};
         end
      end
   end
endmodule : ddmr_dev_model

// [verification/ddmr_ctrl_monitor.sv]
// checker: mode set timing and field rules at the controller pins
`timescale 1ns/1ns
module ddmr_ctrl_monitor
   import ddmr_pkg::*;
#(
   parameter int DLLK_CYC = DDMR_DLLK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic array_idle,
   input wire ddmr_cmd_t dram_cmd,
   input wire logic dram_cke,
   input wire logic dram_odt,
   input wire logic dram_reset_n,
   input wire logic cmd_allowed,
   input wire logic read_allowed
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic mset;
   logic dll_set;
   int dll_cnt;
   logic [2:0] last_cl;
   logic lat_chg;
   // all four strobes low marks a mode set
   assign mset = ~|{dram_cmd.cs_n, dram_cmd.ras_n, dram_cmd.cas_n, dram_cmd.we_n};
   assign dll_set = mset && dram_cmd.bank == 3'h0 && dram_cmd.addr[8];
   assign lat_chg = mset && dram_cmd.bank == 3'h0 && dram_cmd.addr[6:4] != last_cl;
   // latency last sent to the base register; a device reset forgets it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_cl <= 3'h0;
      end else if (!dram_reset_n) begin
         last_cl <= 3'h0;
      end else if (mset && dram_cmd.bank == 3'h0) begin
         last_cl <= dram_cmd.addr[6:4];
      end
   end
   // lock window left after a dll reset; too long for a repetition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_cnt <= 0;
      end else if (dll_set) begin
         dll_cnt <= DLLK_CYC - 1;
      end else if (dll_cnt != 0) begin
         dll_cnt <= dll_cnt - 1;
      end
   end
   sequence base_set_s;
      mset && dram_cmd.bank == 3'h0;
   endsequence
   idle_only_a: assert property (mset |-> $past(array_idle))
      else $error("mode set while array busy");
   mrs_gap_a: assert property (mset |=> !mset [*3])
      else $error("mode sets too close");
   cmd_quiet_a: assert property (mset |-> !cmd_allowed [*6])
      else $error("commands allowed too early");
   cke_hold_a: assert property (mset |-> dram_cke [*6])
      else $error("clock enable dropped too early");
   odt_low_a: assert property (mset |-> !dram_odt [*6])
      else $error("termination on during update");
   rsvd_zero_a: assert property (base_set_s |-> (dram_cmd.addr & 16'h2084) == 16'h0000)
      else $error("reserved bits set");
   wr_code_a: assert property (base_set_s |-> dram_cmd.addr[11:9] == 3'h1)
      else $error("wrong recovery code");
   dll_wait_a: assert property ((dll_set || dll_cnt != 0) |-> !read_allowed)
      else $error("reads allowed during dll lock");
   lat_exit_a: assert property (lat_chg |-> !cmd_allowed [*8])
      else $error("commands allowed before latency exit interval");
endmodule : ddmr_ctrl_monitor
bind ddmr_ctrl ddmr_ctrl_monitor #(.DLLK_CYC(DLLK_CYC)) ddmr_ctrl_monitor_inst (
   .pclk(pclk), .presetn(presetn), .array_idle(array_idle), .dram_cmd(dram_cmd),
   .dram_cke(dram_cke), .dram_odt(dram_odt), .dram_reset_n(dram_reset_n),
   .cmd_allowed(cmd_allowed), .read_allowed(read_allowed));

// [verification/ddmr_ctrl_tb_top.sv]
// testbench: apb driven mode register programming against a device model
`timescale 1ns/1ns
module ddmr_ctrl_tb_top;
   import ddmr_pkg::*;
   typedef struct packed {logic e; logic [31:0] d; logic [31:0] m;} ddmr_exp_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, array_idle;
   logic dram_cke, dram_odt, dram_reset_n, cmd_allowed, read_allowed;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [16:0] v, exp0;
   ddmr_cmd_t dram_cmd;
   ddmr_exp_t expq [$];
   ddmr_exp_t ex;
   int fail_count, n_checks, k;
   ddmr_ctrl #(.MRD_CYC(4), .MOD_CYC(6), .SPDEN_CYC(6), .XPDLL_CYC(9), .DLLK_CYC(16))
   ddmr_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .array_idle(array_idle), .dram_cmd(dram_cmd), .dram_cke(dram_cke),
      .dram_odt(dram_odt), .dram_reset_n(dram_reset_n), .cmd_allowed(cmd_allowed),
      .read_allowed(read_allowed));
   ddmr_dev_model ddmr_dev_model_inst (.pclk(pclk), .dram_cmd(dram_cmd), .dram_cke(dram_cke),
      .dram_reset_n(dram_reset_n));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task check(input logic [32:0] seen, input logic [32:0] want);
      n_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task results();
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // one apb transfer; the expectation is queued for the watcher
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, ed, em);
      int n;
      expq.push_back('{a > 8'h08, ed, em});
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         results();
      end
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask : apb
   task poll(input logic [31:0] m, want);
      int n;
      n = 0;
      do begin
         apb(0, DDMR_STATUS_OFS, 0, 0, 0);
         n++;
      end while ((rd & m) !== want && n < 300);
      if (n >= 300) begin
         fail_count++;
         results();
      end
   endtask : poll
   task prog(input logic [16:0] val, input logic [1:0] tgt, input logic odt);
      apb(1, DDMR_VALUE_OFS, {15'h0, val}, 0, 0);
      apb(1, DDMR_CTRL_OFS, {26'h0, tgt, 2'b00, odt, 1'b1}, 0, 0);
      poll(32'h0000_0007, 32'h0000_0006);
   endtask : prog
   // each answer retires the oldest expectation; pready stands one cycle
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         ex = expq.pop_front();
         check({pslverr, prdata & ex.m}, {ex.e, ex.d & ex.m});
      end
   end
   // banks go busy at random, so commands must wait
   always @(posedge pclk) array_idle <= $urandom_range(0, 3) != 0;
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, array_idle} = '0;
      fail_count = 0;
      n_checks = 0;
      void'($urandom(32'h5ca1393e));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, DDMR_CTRL_OFS, 0, 0, 32'hFFFF_FFFF);
      apb(0, DDMR_VALUE_OFS, 0, 0, 32'hFFFF_FFFF);
      apb(0, DDMR_STATUS_OFS, 0, 32'h0000_0026, 32'hFFFF_FFF7);
      apb(0, 8'h0C, 0, 0, 32'hFFFF_FFFF);
      // every legal burst field, both orders, dll reset each time
      for (k = 0; k < 3; k++) begin
         v = 17'($urandom());
         v[1:0] = k[1:0];
         v[3] = k[0];
         v[6:4] = 3'($urandom_range(1, 6));
         v[8] = 1'b1;
         exp0 = (v & ~(DDMR_RSVD_MASK | 17'h0_0F00)) | 17'h0_0200;
         prog(v, 2'h0, k[0]);
         check({16'h0, ddmr_dev_model_inst.mode_reg[0]}, {16'h0, exp0});
         apb(0, DDMR_VALUE_OFS, 0, 0, 32'h0000_0100);
      end
      // partner burst order: start 1 in both types, chop write from column 7
      for (k = 0; k < 8; k++) begin
         check(33'(ddmr_dev_model_inst.beat_col(3'h1, 3'(k), 1'b0, 1'b0, 1'b0)),
               33'((32'h4765_0321 >> (4 * k)) & 32'h0000_0007));
         check(33'(ddmr_dev_model_inst.beat_col(3'h1, 3'(k), 1'b1, 1'b0, 1'b0)),
               33'((32'h6745_2301 >> (4 * k)) & 32'h0000_0007));
         check(33'(ddmr_dev_model_inst.beat_col(3'h7, 3'(k), 1'b0, 1'b1, 1'b1)),
               33'(4 + k % 4));
         check(33'(ddmr_dev_model_inst.beat_float(1'b1, 3'(k))), 33'(k > 3));
      end
      // refused words: latency code zero, burst field 11
      for (k = 0; k < 2; k++) begin
         v = exp0;
         if (k == 0) v[6:4] = 3'h0;
         else v[1:0] = 2'b11;
         prog(v, 2'h0, 1'b0);
         apb(0, DDMR_STATUS_OFS, 0, 32'h0000_0010, 32'h0000_0010);
         apb(1, DDMR_STATUS_OFS, 32'h0000_0010, 0, 0);
         apb(0, DDMR_STATUS_OFS, 0, 0, 32'h0000_0010);
         check({16'h0, ddmr_dev_model_inst.mode_reg[0]}, {16'h0, exp0});
      end
      v = 17'($urandom());
      prog(v, 2'h2, 1'b1);
      check({16'h0, ddmr_dev_model_inst.mode_reg[2]}, {17'h0, v[15:0]});
      // power-down request drops clock enable, clearing it restores it
      apb(1, DDMR_CTRL_OFS, 32'h0000_0004, 0, 0);
      poll(32'h0000_0020, 32'h0000_0000);
      apb(1, DDMR_CTRL_OFS, 0, 0, 0);
      poll(32'h0000_0020, 32'h0000_0020);
      // device reset wipes device settings and the shadow word
      apb(1, DDMR_CTRL_OFS, 32'h0000_0008, 0, 0);
      apb(1, DDMR_CTRL_OFS, 0, 0, 0);
      check({16'h0, ddmr_dev_model_inst.mode_reg[0]}, 33'h0);
      apb(0, DDMR_VALUE_OFS, 0, 0, 32'hFFFF_FFFF);
      results();
   end
endmodule : ddmr_ctrl_tb_top
